// *** sce_pkg.sv ***
// Package of offsets, field positions and reset values for the socket event registers
package sce_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Window split: 32-bit card half below, 16-bit card half above
  localparam logic [11:0] HALF16_BASE = 12'h800;
  localparam logic [11:0] OFS_EVENT = 12'h000;
  localparam logic [11:0] OFS_MASK = 12'h004;
  localparam logic [11:0] OFS_PRESENT = 12'h008;
  localparam logic [11:0] OFS_FORCE = 12'h00c;
  localparam logic [11:0] OFS_CONTROL = 12'h010;
  localparam logic [11:0] OFS_RSVD_FIRST = 12'h014;
  localparam logic [11:0] OFS_RSVD_LAST = 12'h7fc;

  // Event, mask and force bit positions
  localparam int EVB_STSCHG = 0;
  localparam int EVB_CD1 = 1;
  localparam int EVB_CD2 = 2;
  localparam int EVB_PWR = 3;
  localparam int EV_W = 4;

  // Present state bit positions
  localparam int PSB_STSCHG = 0;
  localparam int PSB_CD1 = 1;
  localparam int PSB_CD2 = 2;
  localparam int PSB_CARD16 = 4;
  localparam int PSB_5V = 28;
  localparam int PSB_3V = 29;

  localparam logic [3:0] EVENT_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [2:0] CONTROL_RST = 3'h0;
  localparam logic [1:0] CD_MASK_ON = 2'h3;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic stschg;
    logic cd1;
    logic cd2;
    logic card16;
  } sce_socket_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } sce_req_t;

endpackage

// *** sce_change_det.sv ***
// Per-bit change detector: flags any change or a rising edge only
`timescale 1ns/1ps
module sce_change_det #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RISE_ONLY = '0
) (
  input wire logic mclk_in, // Clock
  input wire logic resetn_in, // Async reset, active low
  input wire logic [WIDTH-1:0] level_in, // Sampled levels
  output logic [WIDTH-1:0] hit_out // One-cycle change pulses
);

  logic [WIDTH-1:0] prev_r;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_r <= '0;
    end else begin
      prev_r <= level_in;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign hit_out[i] = RISE_ONLY[i] ? (level_in[i] & ~prev_r[i]) : (level_in[i] ^ prev_r[i]);
    end
  endgenerate

endmodule

// *** sce_socket_regs.sv ***
// Socket event, mask, present state and force registers with status-change interrupt
`timescale 1ns/1ps
// How it works
// [RULE1] 4 KB window: 32-bit card registers from 000h, 16-bit half from 800h.
// [RULE2] Socket set holds five dword registers for the socket.
// [RULE3] Offsets 014h to 7FCh read zero and ignore writes.
// [RULE4] Event bits record that a change happened, not its direction.
// [RULE5] Software reads present state to learn the real socket condition.
// [RULE6] Writing one clears an event bit, zero leaves it; reset clears all.
// [RULE7] Writing one to the force register sets the matching event bit.
// [RULE8] PCI reset clears every event bit.
// [RULE9] On card reset release, unchanged asserted status sets its event again.
// [RULE10] Software clears events before enabling interrupts.
// [RULE11] Any set, unmasked event raises the status-change interrupt.
// [RULE12] Event bits 31 to 4 read zero and ignore writes.
// [RULE13] Bit 3 sets when 32-bit socket power-up completes.
// [RULE14] Software checks present state for the applied voltage afterwards.
// [RULE15] Bit 2 sets on any change of second card detect.
// [RULE16] Bit 1 sets on any change of first card detect.
// [RULE17] Bit 0 sets on status-change assertion only, never mirrors the level.
// [RULE18] With a 16-bit card, bit 0 raises no interrupt here.
// [RULE19] Card-detect mask 00 blocks, 11 allows; events still set.
// [RULE20] Removal with card-detect interrupt enabled clears that mask field.
// [RULE21] Interrupt is OR of event AND enabling mask, on the clock.
module sce_socket_regs (
  input wire logic mclk_in, // PCI clock
  input wire logic resetn_in, // PCI reset, active low
  input wire sce_pkg::sce_req_t req_in, // Register access request
  output logic [31:0] rdata_out, // Read data, registered
  output logic rvalid_out, // Read data valid, one cycle
  output logic half16_hit_out, // Access falls in 16-bit card half
  input wire sce_pkg::sce_socket_t sock_in, // Socket levels, 1 = asserted
  input wire logic card_resetn_in, // Card reset, active low
  input wire logic power_up_done_event_in, // Power-up complete pulse
  output logic [2:0] control_out, // Socket control bits
  output logic irq_out // Status-change interrupt
);

  // ****************************************
  // Decode
  // ****************************************
  logic [3:0] event_r;
  logic [3:0] mask_r;
  logic [2:0] control_r;
  logic crst_prev_r;
  logic in_low_half;
  logic wr_event;
  logic wr_mask;
  logic wr_force;
  logic wr_control;
  logic card16;
  logic in_rsvd;
  logic wr_ok;

  assign card16 = sock_in.card16;
  assign in_low_half = (req_in.addr < sce_pkg::HALF16_BASE); // [RULE1]
  // Upper half belongs to the 16-bit card logic; here it only reads zero
  assign half16_hit_out = (req_in.wr | req_in.rd) & ~in_low_half; // [RULE1]
  // Reserved writes are kept out before any offset match
  assign in_rsvd = (req_in.addr >= sce_pkg::OFS_RSVD_FIRST) & (req_in.addr <= sce_pkg::OFS_RSVD_LAST); // [RULE3]
  assign wr_ok = req_in.wr & in_low_half & ~in_rsvd; // [RULE3]
  assign wr_event = wr_ok & (req_in.addr == sce_pkg::OFS_EVENT);
  assign wr_mask = wr_ok & (req_in.addr == sce_pkg::OFS_MASK);
  assign wr_force = wr_ok & (req_in.addr == sce_pkg::OFS_FORCE);
  assign wr_control = wr_ok & (req_in.addr == sce_pkg::OFS_CONTROL);

  // ****************************************
  // Event sources
  // ****************************************
  logic [2:0] lvl;
  logic [2:0] hit;
  logic crst_release;
  logic [3:0] ev_set;
  logic removal;

  assign lvl = {sock_in.cd2, sock_in.cd1, sock_in.stschg};

  // Status change counts on assertion; detects count either way
  sce_change_det #(
    .WIDTH(3),
    .RISE_ONLY(3'b001)
  ) u_det (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .level_in(lvl),
    .hit_out(hit)
  );

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      crst_prev_r <= 1'b0;
    end else begin
      crst_prev_r <= card_resetn_in;
    end
  end

  // History starts low, so a card already out of reset re-reports its levels
  assign crst_release = card_resetn_in & ~crst_prev_r;
  // Removal is taken as the first detect falling
  assign removal = hit[sce_pkg::EVB_CD1] & ~sock_in.cd1;

  // Force bits OR in, so a forced bit and a real event never cancel
  always_comb begin
    ev_set = 4'h0;
    ev_set[sce_pkg::EVB_STSCHG] = hit[0] | (crst_release & sock_in.stschg); // [RULE17] [RULE9]
    ev_set[sce_pkg::EVB_CD1] = hit[1] | (crst_release & sock_in.cd1); // [RULE16] [RULE9]
    ev_set[sce_pkg::EVB_CD2] = hit[2] | (crst_release & sock_in.cd2); // [RULE15] [RULE9]
    ev_set[sce_pkg::EVB_PWR] = power_up_done_event_in; // [RULE13]
    if (wr_force) begin
      ev_set = ev_set | req_in.wdata[3:0]; // [RULE7]
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Hardware set beats a same-cycle software clear, so no event is lost
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      event_r <= sce_pkg::EVENT_RST; // [RULE8]
    end else begin
      event_r <= (event_r & ~(wr_event ? req_in.wdata[3:0] : 4'h0)) | ev_set; // [RULE6] [RULE4]
    end
  end

  logic cd_enable;

  // Codes 01 and 10 count as masked
  assign cd_enable = (mask_r[2:1] == sce_pkg::CD_MASK_ON); // [RULE19]

  // Software write wins over the automatic clear
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mask_r <= sce_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_r <= req_in.wdata[3:0];
    end else if (removal) begin
      mask_r[0] <= 1'b0;
      if (cd_enable) begin
        mask_r[2:1] <= 2'h0; // [RULE20]
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      control_r <= sce_pkg::CONTROL_RST;
    end else if (wr_control) begin
      control_r <= req_in.wdata[2:0];
    end
  end

  assign control_out = control_r;

  // ****************************************
  // Present state
  // ****************************************
  // Live levels only; the event bits keep the history
  logic [31:0] present_word;

  always_comb begin
    present_word = sce_pkg::READ_ZERO;
    present_word[sce_pkg::PSB_STSCHG] = sock_in.stschg;
    present_word[sce_pkg::PSB_CD1] = sock_in.cd1;
    present_word[sce_pkg::PSB_CD2] = sock_in.cd2;
    present_word[sce_pkg::PSB_CARD16] = card16;
    // Both supplies offered, so these never move
    present_word[sce_pkg::PSB_5V] = 1'b1;
    present_word[sce_pkg::PSB_3V] = 1'b1;
  end

  // ****************************************
  // Read path
  // ****************************************
  // Data holds until the next read, so a slow host can still take it
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = sce_pkg::READ_ZERO; // [RULE3]
    unique case (req_in.addr)
      sce_pkg::OFS_EVENT: rd_mux[3:0] = event_r; // [RULE12]
      sce_pkg::OFS_MASK: rd_mux[3:0] = mask_r;
      sce_pkg::OFS_PRESENT: rd_mux = present_word;
      sce_pkg::OFS_CONTROL: rd_mux[2:0] = control_r; // [RULE2]
      default: rd_mux = sce_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= sce_pkg::READ_ZERO;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= req_in.rd;
      if (req_in.rd) begin
        rdata_out <= rd_mux;
      end
    end
  end

  // ****************************************
  // Interrupt
  // ****************************************
  logic [3:0] enable;

  always_comb begin
    enable = 4'h0;
    enable[sce_pkg::EVB_PWR] = mask_r[sce_pkg::EVB_PWR];
    enable[sce_pkg::EVB_CD1] = cd_enable; // [RULE19]
    enable[sce_pkg::EVB_CD2] = cd_enable; // [RULE19]
    enable[sce_pkg::EVB_STSCHG] = mask_r[0] & ~card16; // [RULE18]
  end

  // Registered so the pin never glitches while bits change
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(event_r & enable); // [RULE11] [RULE21]
    end
  end

endmodule

// *** sce_regs_chk_sva.sv ***
// Port assertions for the socket event register block
`timescale 1ns/1ps
module sce_regs_chk (
  input wire logic mclk_in, // Clock
  input wire logic resetn_in, // Reset, active low
  input wire sce_pkg::sce_req_t req_in, // Request
  input wire logic [31:0] rdata_out, // Read data
  input wire logic rvalid_out, // Read valid
  input wire logic half16_hit_out, // Upper half hit
  input wire sce_pkg::sce_socket_t sock_in, // Socket levels
  input wire logic power_up_done_event_in, // Power-up pulse
  input wire logic [2:0] control_out // Control bits
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_ev_rd;
    req_in.rd && !req_in.wr && req_in.addr == sce_pkg::OFS_EVENT;
  endsequence
  sequence s_pwr_rd;
    power_up_done_event_in ##1 !(req_in.wr && req_in.addr == sce_pkg::OFS_EVENT) ##1 s_ev_rd;
  endsequence
  sequence s_cd2_rd;
    $past(resetn_in) && $changed(sock_in.cd2) ##1 s_ev_rd;
  endsequence
  a_read_answer: assert property (req_in.rd |=> rvalid_out) else $error("read not answered");
  a_no_stray_valid: assert property (!req_in.rd |=> !rvalid_out) else $error("stray read valid");
  a_rsvd_zero: assert property (req_in.rd && req_in.addr >= sce_pkg::OFS_RSVD_FIRST
    |=> rdata_out == sce_pkg::READ_ZERO) else $error("reserved read not zero");
  a_half_split: assert property ((req_in.rd || req_in.wr)
    |-> half16_hit_out == (req_in.addr >= sce_pkg::HALF16_BASE)) else $error("half decode wrong");
  a_event_upper: assert property (s_ev_rd |=> rdata_out[31:4] == 28'h0) else $error("event upper bits");
  a_force_wo: assert property (req_in.rd && req_in.addr == sce_pkg::OFS_FORCE
    |=> rdata_out == sce_pkg::READ_ZERO) else $error("force reg readable");
  a_pwr_event: assert property (s_pwr_rd |=> rdata_out[sce_pkg::EVB_PWR]) else $error("power event lost");
  a_cd2_event: assert property (s_cd2_rd |=> rdata_out[sce_pkg::EVB_CD2]) else $error("cd2 event lost");
  a_control_rw: assert property (req_in.wr && req_in.addr == sce_pkg::OFS_CONTROL
    |=> control_out == $past(req_in.wdata[2:0])) else $error("control write lost");
endmodule

// *** sce_card_model.sv ***
// Socket side model: card detects, status change, card reset, power-up
`timescale 1ns/1ps
module sce_card_model (
  input wire logic mclk_in, // Clock
  output sce_pkg::sce_socket_t sock_out, // Socket levels
  output logic crstn_out, // Card reset, active low
  output logic pwr_out // Power-up done pulse
);
  initial {sock_out, crstn_out, pwr_out} = 6'h02;
  // Both detects move together, as on a whole insertion
  task automatic set(input logic cd, input logic st);
    @(posedge mclk_in) #1;
    sock_out = '{stschg: st, cd1: cd, cd2: cd, card16: sock_out.card16};
  endtask
  // Card type: 1 for a 16-bit card
  task automatic kind(input logic c);
    @(posedge mclk_in) #1;
    sock_out.card16 = c;
  endtask
  // One cycle: power-up pulse if p, else card reset low
  task automatic strobe(input logic p);
    @(posedge mclk_in) #1;
    {crstn_out, pwr_out} = {p, p};
    @(posedge mclk_in) #1;
    {crstn_out, pwr_out} = 2'h2;
  endtask
endmodule

// *** cardbus_socket_event_regs_bench.sv ***
// Testbench for the socket event register block
`timescale 1ns/1ps
module cardbus_socket_event_regs_bench;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  sce_pkg::sce_req_t req_in = '0;
  sce_pkg::sce_socket_t sock_in;
  logic crstn, pwr, rvalid_out, irq_out;
  logic [31:0] rdata_out;
  int miscompares = 0;
  int compares = 0;
  always #5 mclk_in = ~mclk_in;
  sce_socket_regs dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .half16_hit_out(), .sock_in(sock_in), .card_resetn_in(crstn),
    .power_up_done_event_in(pwr), .control_out(), .irq_out(irq_out));
  sce_card_model card_u (.mclk_in(mclk_in), .sock_out(sock_in), .crstn_out(crstn), .pwr_out(pwr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Write when w, else read and compare with d
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in) #1;
    req_in = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk_in) #1;
    req_in = '0;
    if (!w) chk(rdata_out, d);
  endtask
  task automatic irq(input logic exp);
    repeat (3) @(posedge mclk_in);
    #1 chk({31'h0, irq_out}, {31'h0, exp});
  endtask
  task automatic conclude();
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    acc(0, 12'h000, 32'h0);
    acc(0, 12'h008, 32'h3000_0000);
    acc(1, 12'h014, 32'hffff_ffff);
    acc(0, 12'h014, 32'h0);
    acc(0, 12'h7fc, 32'h0);
    acc(0, 12'h800, 32'h0);
    acc(1, 12'h010, 32'h5);
    acc(0, 12'h010, 32'h5);
    acc(1, 12'h00c, 32'hffff_ffff);
    acc(0, 12'h000, 32'hf);
    acc(1, 12'h000, 32'h5);
    acc(0, 12'h000, 32'ha);
    acc(1, 12'h000, 32'hf);
    acc(1, 12'h004, 32'h6);
    card_u.set(1, 0);
    irq(1);
    acc(0, 12'h000, 32'h6);
    acc(0, 12'h008, 32'h3000_0006);
    card_u.set(0, 0);
    acc(0, 12'h000, 32'h6);
    acc(0, 12'h004, 32'h0);
    acc(1, 12'h000, 32'hf);
    card_u.set(1, 0);
    irq(0);
    acc(1, 12'h004, 32'h1);
    card_u.set(1, 1);
    irq(1);
    acc(1, 12'h000, 32'hf);
    card_u.set(1, 0);
    acc(0, 12'h000, 32'h0);
    card_u.strobe(0);
    acc(0, 12'h000, 32'h6);
    acc(1, 12'h000, 32'hf);
    acc(1, 12'h004, 32'h8);
    card_u.strobe(1);
    acc(0, 12'h000, 32'h8);
    irq(1);
    acc(0, 12'h008, 32'h3000_0006);
    acc(1, 12'h000, 32'hf);
    acc(1, 12'h004, 32'h1);
    card_u.kind(1);
    card_u.set(1, 1);
    irq(0);
    acc(0, 12'h008, 32'h3000_0017);
    card_u.kind(0);
    irq(1);
    card_u.set(1, 0);
    #1 resetn_in = 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    // Detects still high, so a fresh change is seen
    acc(0, 12'h000, 32'h6);
    acc(0, 12'h004, 32'h0);
    conclude();
  end
endmodule
bind sce_socket_regs sce_regs_chk chk_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out), .half16_hit_out(half16_hit_out), .sock_in(sock_in),
  .power_up_done_event_in(power_up_done_event_in), .control_out(control_out));
